// *** scan_sequencer.sv ***
// Linear voltage scan sequencer with an Avalon-MM register slave.
//
// The Avalon-MM interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps
module scan_sequencer #(
    parameter int TICK_CYCLES = scan_seq_pkg::TICK_CYCLES
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic [31:0] VOLTAGE_SETPOINT,
    output logic [1:0] SCAN_ARM_STATE
);
    scan_seq_pkg::scan_cfg_t cfg_q;
    scan_seq_pkg::scan_state_t state_q;
    logic [1:0] out_range_q;
    logic out_enable_q;
    logic signed [31:0] set_q;
    logic param_reject_q;
    logic arm_refused_q;
    logic resp_q;
    logic [31:0] rdata_q;
    logic [31:0] quo_q;
    logic [16:0] rem_q;
    logic [17:0] err_q;
    logic [16:0] tick_cnt_q;
    logic dir_up_q;

    logic wr_go;
    logic running;
    logic idle;
    logic [31:0] wdata;
    logic signed [31:0] scan_limit;
    logic signed [31:0] out_limit;
    logic begin_ok;
    logic end_ok;
    logic voltage_setpoint_ok;
    logic [31:0] dur_rounded;
    logic dur_ok;
    logic arm_ok;
    logic trig_go;
    logic div_start;
    logic div_done;
    logic [31:0] div_quo;
    logic [31:0] div_rem;
    logic [31:0] span_mag;
    logic tick;
    logic restart_tick;
    logic [17:0] err_sum;
    logic carry;
    logic [31:0] step;
    logic signed [31:0] stepped;
    logic last_tick;
    logic signed [31:0] target;

    ////////////////////////////////////////////////////////////////////////
    // Range limit lookup.
    function automatic logic signed [31:0] range_limit(input logic [1:0] sel);
        logic signed [31:0] lim;
        lim = scan_seq_pkg::LIMIT_ONE_VOLTAGE_SETPOINT;
        case (sel)
            scan_seq_pkg::RANGE_TEN_VOLTAGE_SETPOINT: lim = scan_seq_pkg::LIMIT_TEN_VOLTAGE_SETPOINT;
            scan_seq_pkg::RANGE_HUNDRED_VOLTAGE_SETPOINT: lim = scan_seq_pkg::LIMIT_HUNDRED_VOLTAGE_SETPOINT;
            default: lim = scan_seq_pkg::LIMIT_ONE_VOLTAGE_SETPOINT;
        endcase
        return lim;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle on every access.
    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !resp_q;
    assign wr_go = AVS_WRITE && resp_q && (AVS_BYTEENABLE == 4'hf);
    assign wdata = AVS_WRITEDATA;
    assign AVS_READDATA = rdata_q;
    assign VOLTAGE_SETPOINT = set_q;
    assign idle = (state_q == scan_seq_pkg::ST_IDLE);
    assign running = (state_q == scan_seq_pkg::ST_DIVIDE) ||
                     (state_q == scan_seq_pkg::ST_RAMP_OUT) ||
                     (state_q == scan_seq_pkg::ST_RAMP_BACK);

    always_comb begin
        case (state_q)
            scan_seq_pkg::ST_IDLE: SCAN_ARM_STATE = scan_seq_pkg::ARM_IDLE;
            scan_seq_pkg::ST_ARMED: SCAN_ARM_STATE = scan_seq_pkg::ARM_ARMED;
            default: SCAN_ARM_STATE = scan_seq_pkg::ARM_SCANNING;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            resp_q <= 1'b0;
        end else begin
            resp_q <= (AVS_READ || AVS_WRITE) && !resp_q;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            rdata_q <= '0;
        end else if (AVS_READ && !resp_q) begin
            case (AVS_ADDRESS)
                scan_seq_pkg::ADDR_SCAN_RANGE: rdata_q <= {30'h0, cfg_q.range_sel};
                scan_seq_pkg::ADDR_SCAN_BEGIN: rdata_q <= cfg_q.begin_volts;
                scan_seq_pkg::ADDR_SCAN_END: rdata_q <= cfg_q.end_volts;
                scan_seq_pkg::ADDR_SCAN_DURATION: rdata_q <= {15'h0, cfg_q.duration};
                scan_seq_pkg::ADDR_SCAN_SHAPE: rdata_q <= {31'h0, cfg_q.shape};
                scan_seq_pkg::ADDR_SCAN_CYCLE: rdata_q <= {31'h0, cfg_q.cycle_mode};
                scan_seq_pkg::ADDR_SCAN_ARM: rdata_q <= {30'h0, SCAN_ARM_STATE};
                scan_seq_pkg::ADDR_OUTPUT_RANGE: rdata_q <= {30'h0, out_range_q};
                scan_seq_pkg::ADDR_OUTPUT_ENABLE: rdata_q <= {31'h0, out_enable_q};
                scan_seq_pkg::ADDR_VOLTAGE: rdata_q <= set_q;
                scan_seq_pkg::ADDR_STATUS: rdata_q <= {30'h0, arm_refused_q, param_reject_q};
                default: rdata_q <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Value checks for parameter writes.
    // range limit check.
    assign scan_limit = range_limit(cfg_q.range_sel);
    assign out_limit = range_limit(out_range_q);
    assign begin_ok = ($signed(wdata) <= scan_limit) && ($signed(wdata) >= -scan_limit);
    assign end_ok = begin_ok;
    assign voltage_setpoint_ok = ($signed(wdata) <= out_limit) && ($signed(wdata) >= -out_limit);
    assign dur_rounded = (wdata + scan_seq_pkg::DUR_ROUND_MS) / scan_seq_pkg::MS_PER_TENTH;
    assign dur_ok = (wdata >= scan_seq_pkg::DUR_MIN_MS) && (wdata <= scan_seq_pkg::DUR_MAX_MS);

    assign arm_ok = out_enable_q && (cfg_q.range_sel == out_range_q) &&
                    (cfg_q.begin_volts != cfg_q.end_volts);

    ////////////////////////////////////////////////////////////////////////
    // Scan parameter store.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            cfg_q.range_sel <= scan_seq_pkg::RANGE_RST;
            cfg_q.begin_volts <= scan_seq_pkg::BEGIN_RST;
            cfg_q.end_volts <= scan_seq_pkg::END_RST;
            cfg_q.duration <= scan_seq_pkg::DURATION_RST;
            cfg_q.shape <= scan_seq_pkg::SHAPE_RST;
            cfg_q.cycle_mode <= scan_seq_pkg::CYCLE_RST;
            param_reject_q <= 1'b0;
        end else if (wr_go) begin
            if (AVS_ADDRESS == scan_seq_pkg::ADDR_SCAN_CYCLE) begin
                cfg_q.cycle_mode <= wdata[0];
            end
            case (AVS_ADDRESS)
                scan_seq_pkg::ADDR_SCAN_RANGE: begin
                    if (!idle || wdata > 32'h2) begin
                        param_reject_q <= 1'b1;
                    end else begin
                        cfg_q.range_sel <= wdata[1:0];
                        param_reject_q <= 1'b0;
                        if (wdata[1:0] != cfg_q.range_sel) begin
                            cfg_q.begin_volts <= '0;
                            cfg_q.end_volts <= '0;
                        end
                    end
                end
                scan_seq_pkg::ADDR_SCAN_BEGIN: begin
                    if (!idle || !begin_ok) begin
                        param_reject_q <= 1'b1;
                    end else begin
                        cfg_q.begin_volts <= $signed(wdata);
                        param_reject_q <= 1'b0;
                    end
                end
                scan_seq_pkg::ADDR_SCAN_END: begin
                    if (!idle || !end_ok) begin
                        param_reject_q <= 1'b1;
                    end else begin
                        cfg_q.end_volts <= $signed(wdata);
                        param_reject_q <= 1'b0;
                    end
                end
                scan_seq_pkg::ADDR_SCAN_DURATION: begin
                    if (!idle || !dur_ok) begin
                        param_reject_q <= 1'b1;
                    end else begin
                        cfg_q.duration <= dur_rounded[16:0];
                        param_reject_q <= 1'b0;
                    end
                end
                scan_seq_pkg::ADDR_SCAN_SHAPE: begin
                    if (!idle || wdata > 32'h1) begin
                        param_reject_q <= 1'b1;
                    end else begin
                        cfg_q.shape <= wdata[0];
                        param_reject_q <= 1'b0;
                    end
                end
                scan_seq_pkg::ADDR_VOLTAGE: begin
                    param_reject_q <= !idle || !voltage_setpoint_ok;
                end
                default: begin
                end
            endcase
        end
    end

    // Output configuration, writable at any time.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            out_range_q <= scan_seq_pkg::RANGE_RST;
            out_enable_q <= 1'b0;
        end else if (wr_go) begin
            if (AVS_ADDRESS == scan_seq_pkg::ADDR_OUTPUT_RANGE && wdata <= 32'h2) begin
                out_range_q <= wdata[1:0];
            end
            if (AVS_ADDRESS == scan_seq_pkg::ADDR_OUTPUT_ENABLE) begin
                out_enable_q <= wdata[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ramp arithmetic.
    assign trig_go = wr_go && (AVS_ADDRESS == scan_seq_pkg::ADDR_SCAN_TRIGGER);
    assign span_mag = (cfg_q.end_volts >= cfg_q.begin_volts) ?
                      32'(cfg_q.end_volts - cfg_q.begin_volts) :
                      32'(cfg_q.begin_volts - cfg_q.end_volts);
    assign err_sum = err_q + {1'b0, rem_q};
    assign carry = (err_sum >= {1'b0, cfg_q.duration});
    assign step = quo_q + {31'h0, carry};
    assign stepped = dir_up_q ? set_q + $signed(step) : set_q - $signed(step);
    assign last_tick = (tick_cnt_q == cfg_q.duration - 17'd1);
    assign target = (state_q == scan_seq_pkg::ST_RAMP_BACK) ? cfg_q.begin_volts :
                    cfg_q.end_volts;
    assign restart_tick = div_done || (tick && last_tick);

    scan_divider #(.W(32)) u_div (
        .clk(CLK),
        .reset(RESET),
        .start(div_start),
        .dividend(span_mag),
        .divisor({15'h0, cfg_q.duration}),
        .done(div_done),
        .quotient(div_quo),
        .remainder(div_rem)
    );

    scan_tick_gen #(.CYCLES(TICK_CYCLES)) u_tick (
        .clk(CLK),
        .reset(RESET),
        .restart(restart_tick),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Scan state machine and setpoint.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            state_q <= scan_seq_pkg::ST_IDLE;
            set_q <= scan_seq_pkg::VOLTAGE_SETPOINT_RST;
            arm_refused_q <= 1'b0;
            div_start <= 1'b0;
            quo_q <= '0;
            rem_q <= '0;
            err_q <= '0;
            tick_cnt_q <= '0;
            dir_up_q <= 1'b0;
        end else begin
            div_start <= 1'b0;
            if (wr_go && AVS_ADDRESS == scan_seq_pkg::ADDR_SCAN_ARM && !wdata[0]) begin
                state_q <= scan_seq_pkg::ST_IDLE;
            end else begin
                case (state_q)
                    scan_seq_pkg::ST_IDLE: begin
                        if (wr_go && AVS_ADDRESS == scan_seq_pkg::ADDR_VOLTAGE && voltage_setpoint_ok) begin
                            set_q <= $signed(wdata);
                        end
                        if (wr_go && AVS_ADDRESS == scan_seq_pkg::ADDR_SCAN_ARM) begin
                            arm_refused_q <= !arm_ok;
                            if (arm_ok) begin
                                state_q <= scan_seq_pkg::ST_ARMED;
                            end
                        end
                    end
                    scan_seq_pkg::ST_ARMED: begin
                        if (trig_go) begin
                            set_q <= cfg_q.begin_volts;
                            div_start <= 1'b1;
                            dir_up_q <= cfg_q.end_volts > cfg_q.begin_volts;
                            state_q <= scan_seq_pkg::ST_DIVIDE;
                        end
                    end
                    scan_seq_pkg::ST_DIVIDE: begin
                        if (div_done) begin
                            quo_q <= div_quo;
                            rem_q <= div_rem[16:0];
                            err_q <= '0;
                            tick_cnt_q <= '0;
                            state_q <= scan_seq_pkg::ST_RAMP_OUT;
                        end
                    end
                    scan_seq_pkg::ST_RAMP_OUT, scan_seq_pkg::ST_RAMP_BACK: begin
                        if (tick) begin
                            err_q <= carry ? err_sum - {1'b0, cfg_q.duration} : err_sum;
                            tick_cnt_q <= tick_cnt_q + 17'd1;
                            set_q <= stepped;
                            if (last_tick) begin
                                set_q <= target;
                                err_q <= '0;
                                tick_cnt_q <= '0;
                                if (state_q == scan_seq_pkg::ST_RAMP_OUT &&
                                    cfg_q.shape == scan_seq_pkg::SHAPE_ROUND_TRIP) begin
                                    dir_up_q <= !dir_up_q;
                                    state_q <= scan_seq_pkg::ST_RAMP_BACK;
                                end else if (cfg_q.cycle_mode == scan_seq_pkg::CYCLE_REPEAT) begin
                                    state_q <= scan_seq_pkg::ST_RAMP_OUT;
                                    if (state_q == scan_seq_pkg::ST_RAMP_BACK) begin
                                        dir_up_q <= !dir_up_q;
                                    end else begin
                                        set_q <= cfg_q.begin_volts;
                                    end
                                end else begin
                                    state_q <= scan_seq_pkg::ST_IDLE;
                                end
                            end
                        end
                    end
                    default: state_q <= scan_seq_pkg::ST_IDLE;
                endcase
            end
        end
    end
endmodule // scan_sequencer

// *** scan_seq_pkg.sv ***
// Constants, field layouts and types shared by the linear scan sequencer.
package scan_seq_pkg;
    localparam int VOLTAGE_SETPOINT_W = 32;
    localparam int DUR_W = 17;
    localparam int ADDR_W = 8;

    localparam logic [7:0] ADDR_SCAN_RANGE = 8'h00;
    localparam logic [7:0] ADDR_SCAN_BEGIN = 8'h04;
    localparam logic [7:0] ADDR_SCAN_END = 8'h08;
    localparam logic [7:0] ADDR_SCAN_DURATION = 8'h0c;
    localparam logic [7:0] ADDR_SCAN_SHAPE = 8'h10;
    localparam logic [7:0] ADDR_SCAN_CYCLE = 8'h14;
    localparam logic [7:0] ADDR_SCAN_ARM = 8'h18;
    localparam logic [7:0] ADDR_SCAN_TRIGGER = 8'h1c;
    localparam logic [7:0] ADDR_OUTPUT_RANGE = 8'h20;
    localparam logic [7:0] ADDR_OUTPUT_ENABLE = 8'h24;
    localparam logic [7:0] ADDR_VOLTAGE = 8'h28;
    localparam logic [7:0] ADDR_STATUS = 8'h2c;

    localparam logic [1:0] RANGE_ONE_VOLTAGE_SETPOINT = 2'h0;
    localparam logic [1:0] RANGE_TEN_VOLTAGE_SETPOINT = 2'h1;
    localparam logic [1:0] RANGE_HUNDRED_VOLTAGE_SETPOINT = 2'h2;
    localparam logic SHAPE_SINGLE_DIRECTION = 1'b0;
    localparam logic SHAPE_ROUND_TRIP = 1'b1;
    localparam logic CYCLE_ONCE = 1'b0;
    localparam logic CYCLE_REPEAT = 1'b1;
    localparam logic [1:0] ARM_IDLE = 2'h0;
    localparam logic [1:0] ARM_ARMED = 2'h1;
    localparam logic [1:0] ARM_SCANNING = 2'h2;

    // Voltages are signed microvolts.
    localparam logic signed [31:0] LIMIT_ONE_VOLTAGE_SETPOINT = 32'sd1010000;
    localparam logic signed [31:0] LIMIT_TEN_VOLTAGE_SETPOINT = 32'sd10100000;
    localparam logic signed [31:0] LIMIT_HUNDRED_VOLTAGE_SETPOINT = 32'sd101000000;

    localparam logic [1:0] RANGE_RST = 2'h0;
    localparam logic signed [31:0] BEGIN_RST = 32'sd0;
    localparam logic signed [31:0] END_RST = 32'sd1000000;
    localparam logic signed [31:0] VOLTAGE_SETPOINT_RST = 32'sd0;
    localparam logic [16:0] DURATION_RST = 17'd10;
    localparam logic SHAPE_RST = 1'b0;
    localparam logic CYCLE_RST = 1'b0;

    // Durations are written in milliseconds and stored in tenths of a second.
    localparam logic [31:0] DUR_MIN_MS = 32'd100;
    localparam logic [31:0] DUR_MAX_MS = 32'd9999900;
    localparam logic [31:0] DUR_ROUND_MS = 32'd50;
    localparam logic [31:0] MS_PER_TENTH = 32'd100;

    localparam int CLK_HZ = 100000000;
    localparam int TICK_MS = 100;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

    typedef struct packed {
        logic [1:0] range_sel;
        logic signed [31:0] begin_volts;
        logic signed [31:0] end_volts;
        logic [16:0] duration;
        logic shape;
        logic cycle_mode;
    } scan_cfg_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARMED,
        ST_DIVIDE,
        ST_RAMP_OUT,
        ST_RAMP_BACK
    } scan_state_t;
endpackage

// *** scan_divider.sv ***
// Sequential unsigned restoring divider.
`timescale 1ns/10ps
module scan_divider #(
    parameter int W = 32
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic start,
    input wire logic [W-1:0] dividend,
    input wire logic [W-1:0] divisor,
    output logic done,
    output logic [W-1:0] quotient,
    output logic [W-1:0] remainder
);
    logic [W:0] rem_q;
    logic [W-1:0] quo_q;
    logic [$clog2(W+1)-1:0] cnt_q;
    logic busy_q;
    logic [W:0] shifted;
    logic [W:0] diff;

    assign shifted = {rem_q[W-1:0], quo_q[W-1]};
    assign diff = shifted - {1'b0, divisor};
    assign quotient = quo_q;
    assign remainder = rem_q[W-1:0];

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (reset) begin
            rem_q <= '0;
            quo_q <= '0;
            cnt_q <= '0;
            busy_q <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                rem_q <= '0;
                quo_q <= dividend;
                cnt_q <= ($clog2(W+1))'(W);
                busy_q <= 1'b1;
            end else if (busy_q) begin
                if (!diff[W]) begin
                    rem_q <= diff;
                    quo_q <= {quo_q[W-2:0], 1'b1};
                end else begin
                    rem_q <= shifted;
                    quo_q <= {quo_q[W-2:0], 1'b0};
                end
                cnt_q <= cnt_q - 1'b1;
                if (cnt_q == 1) begin
                    busy_q <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule // scan_divider

// *** scan_tick_gen.sv ***
// Divider that gives a one-cycle enable pulse every CYCLES clocks.
`timescale 1ns/10ps
module scan_tick_gen #(
    parameter int CYCLES = 10000000
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic restart,
    output logic tick
);
    localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    logic [CW-1:0] cnt_q;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (reset || restart) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else if (cnt_q == CW'(CYCLES - 1)) begin
            cnt_q <= '0;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule // scan_tick_gen

// *** scan_seq_pkg_end_marker_unused.sv ***
// Intentionally empty compile unit.
`timescale 1ns/10ps

// *** scan_seq_monitor.sv ***
// Port checks for the scan sequencer.
`timescale 1ns/10ps
module scan_seq_monitor (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic AVS_WAITREQUEST,
    input wire logic [31:0] VOLTAGE_SETPOINT,
    input wire logic [1:0] SCAN_ARM_STATE
);
    default clocking dc @(posedge CLK); endclocking
    default disable iff (RESET);
    wire req = AVS_READ | AVS_WRITE;
    wait_one_a: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("wait state too long");
    wait_idle_a: assert property (!req |-> !AVS_WAITREQUEST)
        else $error("wait without request");
    scan_entry_a: assert property ($rose(SCAN_ARM_STATE[1]) |-> $past(SCAN_ARM_STATE) == 2'h1)
        else $error("scan entered without arm");
    wait_first_a: assert property (req && !$past(req) |-> AVS_WAITREQUEST)
        else $error("request answered without wait state");
    trig_armed_a: assert property (SCAN_ARM_STATE == 2'h0 |=> SCAN_ARM_STATE != 2'h2)
        else $error("scan without arm");
    armed_hold_a: assert property (SCAN_ARM_STATE == 2'h1 && $past(SCAN_ARM_STATE) == 2'h1
        |-> $stable(VOLTAGE_SETPOINT)) else $error("setpoint moved while armed");
    idle_hold_a: assert property ($past(SCAN_ARM_STATE) != 2'h2 && !$past(AVS_WRITE)
        |-> $stable(VOLTAGE_SETPOINT)) else $error("setpoint moved at rest");
    voltage_setpoint_limit_a: assert property ($signed(VOLTAGE_SETPOINT) >= -32'sh6052340
        && $signed(VOLTAGE_SETPOINT) <= 32'sh6052340) else $error("setpoint out of range");
    tick_gap_a: assert property (SCAN_ARM_STATE == 2'h2 && $changed(VOLTAGE_SETPOINT)
        |=> $stable(VOLTAGE_SETPOINT)) else $error("setpoint steps too fast");
endmodule // scan_seq_monitor
bind scan_sequencer scan_seq_monitor u_scan_seq_monitor (.CLK(CLK), .RESET(RESET),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .VOLTAGE_SETPOINT(VOLTAGE_SETPOINT), .SCAN_ARM_STATE(SCAN_ARM_STATE));

// *** scan_host.sv ***
// Remote host model issuing Avalon-MM register cycles.
`timescale 1ns/10ps
module scan_host (
    input wire logic clk,
    input wire logic waitrequest,
    input wire logic [31:0] readdata,
    output logic [7:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata
);
    initial begin
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
    end
    // One cycle held until waitrequest is sampled low; released lines show the inverse.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        address <= ~a;
        writedata <= ~d;
    endtask
endmodule // scan_host

// *** scan_sequencer_tb.sv ***
// Self-checking bench for the scan sequencer.
`timescale 1ns/10ps
module scan_sequencer_tb;
    localparam int TICK = 32;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic read, write, waitrequest;
    logic [7:0] address;
    logic [31:0] writedata, readdata, sp, q;
    logic [1:0] st;
    int n_errors = 0;
    int check_count = 0;
    int n;
    always #5 clk = ~clk;
    scan_sequencer #(.TICK_CYCLES(TICK)) u_scan_sequencer (.CLK(clk), .RESET(reset),
        .AVS_ADDRESS(address), .AVS_READ(read), .AVS_WRITE(write), .AVS_WRITEDATA(writedata),
        .AVS_BYTEENABLE(4'hf), .AVS_READDATA(readdata), .AVS_WAITREQUEST(waitrequest),
        .VOLTAGE_SETPOINT(sp), .SCAN_ARM_STATE(st));
    scan_host u_scan_host (.clk(clk), .waitrequest(waitrequest), .readdata(readdata),
        .address(address), .read(read), .write(write), .writedata(writedata));
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_scan_host.xfer(1'b1, a, d, q);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        u_scan_host.xfer(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask
    task automatic idle_wait;
        for (n = 0; n < 3000 && st !== 2'h0; n++) @(negedge clk);
        chk({30'h0, st}, 32'h0);
    endtask
    task automatic t_defaults;
        logic [31:0] ex [7] = '{32'h0, 32'h0, 32'hf4240, 32'ha, 32'h0, 32'h0, 32'h0};
        for (int i = 0; i < 7; i++) rdchk(8'(i * 4), ex[i]);
    endtask
    task automatic t_limits;
        wr(8'h04, 32'hf6951);
        rdchk(8'h2c, 32'h1);
        rdchk(8'h04, 32'h0);
        wr(8'h04, 32'hf6950);
        rdchk(8'h04, 32'hf6950);
        wr(8'h08, 32'hfff096b0);
        rdchk(8'h08, 32'hfff096b0);
        wr(8'h00, 32'h1);
        rdchk(8'h04, 32'h0);
        rdchk(8'h08, 32'h0);
        wr(8'h04, 32'h9a1d20);
        rdchk(8'h04, 32'h9a1d20);
        wr(8'h00, 32'h0);
        rdchk(8'h04, 32'h0);
    endtask
    task automatic t_dur;
        logic [31:0] ms [5] = '{32'h63, 32'h95, 32'h96, 32'h98961c, 32'h98961d};
        logic [31:0] ex [5] = '{32'ha, 32'h1, 32'h2, 32'h1869f, 32'h1869f};
        for (int i = 0; i < 5; i++) begin
            wr(8'h0c, ms[i]);
            rdchk(8'h0c, ex[i]);
        end
        wr(8'h0c, 32'h12c);
    endtask
    task automatic t_arm;
        wr(8'h1c, 32'h0);
        rdchk(8'h18, 32'h0);
        wr(8'h04, 32'h493e0);
        wr(8'h08, 32'hfffb6c20);
        wr(8'h18, 32'h1);
        rdchk(8'h18, 32'h0);
        rdchk(8'h2c, 32'h2);
        wr(8'h20, 32'h1);
        wr(8'h24, 32'h1);
        wr(8'h18, 32'h1);
        rdchk(8'h18, 32'h0);
        wr(8'h20, 32'h0);
        wr(8'h08, 32'h493e0);
        wr(8'h18, 32'h1);
        rdchk(8'h18, 32'h0);
        wr(8'h08, 32'hfffb6c20);
        wr(8'h28, 32'hf6951);
        rdchk(8'h28, 32'h0);
        wr(8'h28, 32'hf6950);
        rdchk(8'h28, 32'hf6950);
    endtask
    task automatic t_once;
        wr(8'h18, 32'h1);
        wr(8'h04, 32'h0);
        rdchk(8'h04, 32'h493e0);
        // Arm precedes trigger, as the host must.
        wr(8'h1c, 32'h0);
        @(negedge clk);
        chk({30'h0, st}, 32'h2);
        for (int i = 0; i < 500 && sp === 32'h493e0; i++) @(negedge clk);
        chk(sp, 32'h186a0);
        idle_wait();
        chk(sp, 32'hfffb6c20);
    endtask
    task automatic t_round;
        wr(8'h10, 32'h1);
        wr(8'h18, 32'h1);
        wr(8'h1c, 32'h0);
        idle_wait();
        chk(32'(n >= 6 * TICK), 32'h1);
        chk(32'(n <= 8 * TICK), 32'h1);
        chk(sp, 32'h493e0);
    endtask
    task automatic t_repeat;
        logic seen = 1'b0;
        logic jump = 1'b0;
        logic [31:0] prev = 32'h0;
        wr(8'h10, 32'h0);
        wr(8'h14, 32'h1);
        wr(8'h18, 32'h1);
        wr(8'h1c, 32'h0);
        repeat (400) begin
            @(negedge clk);
            seen = seen | (sp === 32'hfffb6c20);
            jump = jump | (prev === 32'hfffe7960 && sp === 32'h493e0);
            prev = sp;
        end
        chk({30'h0, st}, 32'h2);
        chk({31'h0, seen}, 32'h0);
        chk({31'h0, jump}, 32'h1);
        wr(8'h14, 32'h0);
        idle_wait();
        chk(sp, 32'hfffb6c20);
    endtask
    task automatic results;
        if (n_errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        t_defaults();
        t_limits();
        t_dur();
        t_arm();
        t_once();
        t_round();
        t_repeat();
        results();
    end
    initial begin
        #100000;
        n_errors++;
        results();
    end
endmodule // scan_sequencer_tb
